// >>> hdl/hfo_framer.sv
// Frame overhead generator with loop start-up logic and payload FIFO
`timescale 1ns/100ps

module hfo_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             ce_i,
   input  wire logic             in_valid_i,
   output      logic             in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output      logic             out_valid_o,
   input  wire logic             out_ready_i,
   output      logic [WIDTH-1:0] out_data_o
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
      $error("hfo_fifo: DEPTH must be a power of two");
   end
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } hfo_fifo_s;
   hfo_fifo_s s_q, s_d;
   logic push, pop;

   assign in_ready_o  = (s_q.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (s_q.cnt != '0);
   assign out_data_o  = s_q.mem[s_q.rp];
   assign push        = ce_i && in_valid_i && in_ready_o;
   assign pop         = ce_i && out_valid_o && out_ready_i;

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wp] = in_data_i;
         s_d.wp          = s_q.wp + 1'b1;
      end
      if (pop) begin
         s_d.rp = s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// Contract
// - Frame bit 15 carries the far-end loss-of-input flag.
// - Bits 1763 and 1764 carry remote power status, sent by remote only.
// - Bits 3513 to 3516 carry the four regenerator indications in order.
// - Remote checks received loop ids, swaps paths if wrong, returns its id.
// - Both loop reversal enables in register 06h must be set to turn on automatic path switch.
// - Ready-to-receive bit is sent only when ready for payload.
// - Automatic loop swap moves selected channels to the surviving loop.
module hfo_framer #(
   parameter logic [13:0] SYNC_WORD = 14'h3c5a,
   parameter int          FIFO_W    = 8,
   parameter int          FIFO_D    = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             ce_i,
   input  wire logic [6:0]       addr_i,
   input  wire logic             wr_i,
   input  wire logic             rd_i,
   input  wire logic [7:0]       wr_data_i,
   output      logic [7:0]       rd_data_o,
   input  wire logic             far_end_loss_i,
   input  wire logic             febe_i,
   input  wire logic             remote_power_status_a_i,
   input  wire logic             remote_power_status_b_i,
   input  wire logic [3:0]       regen_ind_i,
   input  wire logic [2:0]       rx_loop_id_a_i,
   input  wire logic [2:0]       rx_loop_id_b_i,
   input  wire logic             rx_loop_id_valid_i,
   input  wire logic [1:0]       loop_fail_i,
   input  wire logic             pay_valid_i,
   output      logic             pay_ready_o,
   input  wire logic [FIFO_W-1:0] pay_data_i,
   output      logic             tx_bit_o,
   output      logic             tx_frame_start_o,
   output      logic             path_swap_o,
   output      logic             loop_swap_o
);
   if (FIFO_W != 8) begin : g_width_check
      $error("hfo_framer: payload bytes are 8 bits wide");
   end

   typedef struct packed {
      logic [7:0]  ctrl;
      logic [2:0]  ztx;
      logic [7:0]  slot;
      logic [12:0] fbit;
      logic [7:0]  sh;
      logic [2:0]  nb;
      logic        txb;
      logic        fst;
      logic        los_s1;
      logic        los_s2;
      logic [1:0]  fail_s1;
      logic [1:0]  fail_s2;
      logic        rev;
      logic        swap;
      logic [7:0]  rdata;
   } hfo_top_s;
   hfo_top_s s_q, s_d;

   logic       fifo_valid;
   logic       fifo_pop;
   logic [7:0] fifo_data;
   logic       advance;
   logic       is_pay;
   logic       is_z;
   logic [1:0] z_idx;
   logic [2:0] id_ret;
   logic       remote;

   hfo_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) hfo_fifo_i (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .ce_i        (ce_i),
      .in_valid_i  (pay_valid_i),
      .in_ready_o  (pay_ready_o),
      .in_data_i   (pay_data_i),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_data)
   );

   assign remote  = s_q.ctrl[hfo_pkg::CTRL_REMOTE];
   assign advance = s_q.ctrl[hfo_pkg::CTRL_TXEN];
   assign is_pay  = (s_q.fbit >= hfo_pkg::FB_Z1 && s_q.fbit <= hfo_pkg::FB_PAY1_LAST)
                 || (s_q.fbit >= hfo_pkg::FB_PAY2_FIRST && s_q.fbit <= hfo_pkg::FB_PAY2_LAST)
                 || (s_q.fbit >= hfo_pkg::FB_PAY3_FIRST && s_q.fbit <= hfo_pkg::FB_PAY3_LAST)
                 || (s_q.fbit >= hfo_pkg::FB_PAY4_FIRST && s_q.fbit <= hfo_pkg::FB_PAY4_LAST);
   // Z-bit m is the first bit of FB_BLK_LEN-bit block m of payload block 1
   assign is_z    = (s_q.fbit == hfo_pkg::FB_Z1)
                 || (s_q.fbit == hfo_pkg::FB_Z1 + hfo_pkg::FB_BLK_LEN)
                 || (s_q.fbit == hfo_pkg::FB_Z1 + 13'h0002 * hfo_pkg::FB_BLK_LEN);
   assign z_idx   = (s_q.fbit == hfo_pkg::FB_Z1) ? 2'h0 :
                    (s_q.fbit == hfo_pkg::FB_Z1 + hfo_pkg::FB_BLK_LEN) ? 2'h1 : 2'h2;
   assign id_ret  = s_q.rev ? rx_loop_id_b_i : rx_loop_id_a_i;
   assign fifo_pop = advance && is_pay && !is_z && s_q.nb == 3'h0;

   assign rd_data_o        = s_q.rdata;
   assign tx_bit_o         = s_q.txb;
   assign tx_frame_start_o = s_q.fst;
   assign path_swap_o      = s_q.rev;
   assign loop_swap_o      = s_q.swap;

   always_comb begin
      s_d = s_q;
      s_d.los_s1  = far_end_loss_i;
      s_d.los_s2  = s_q.los_s1;
      s_d.fail_s1 = loop_fail_i;
      s_d.fail_s2 = s_q.fail_s1;
      if (wr_i) begin
         unique case (addr_i)
            hfo_pkg::REG_CTRL: s_d.ctrl = wr_data_i;
            hfo_pkg::REG_ZTX:  s_d.ztx  = wr_data_i[2:0];
            hfo_pkg::REG_SLOT: s_d.slot = wr_data_i;
            default:           s_d.ctrl = s_q.ctrl;
         endcase
      end
      if (rd_i) begin
         unique case (addr_i)
            hfo_pkg::REG_CTRL: s_d.rdata = s_q.ctrl;
            hfo_pkg::REG_ZTX:  s_d.rdata = {5'h00, s_q.ztx};
            hfo_pkg::REG_STAT: s_d.rdata = {2'h0, rx_loop_id_a_i, s_q.los_s2, s_q.swap, s_q.rev};
            hfo_pkg::REG_SLOT: s_d.rdata = s_q.slot;
            default:           s_d.rdata = 8'h00;
         endcase
      end
      if (s_q.slot[hfo_pkg::SLOT_LPR_A] && s_q.slot[hfo_pkg::SLOT_LPR_B]
          && rx_loop_id_valid_i) begin
         if (rx_loop_id_a_i == hfo_pkg::ID_LOOP_B && rx_loop_id_b_i == hfo_pkg::ID_LOOP_A) begin
            s_d.rev = 1'b1;
         end else if (rx_loop_id_a_i == hfo_pkg::ID_LOOP_A
                      && rx_loop_id_b_i == hfo_pkg::ID_LOOP_B) begin
            s_d.rev = 1'b0;
         end
      end
      s_d.swap = s_q.slot[hfo_pkg::SLOT_SWAP] && s_q.fail_s2[0] && !s_q.fail_s2[1];
      if (advance) begin
         s_d.fst  = (s_q.fbit == hfo_pkg::FB_FIRST);
         s_d.fbit = (s_q.fbit == hfo_pkg::FB_LAST) ? hfo_pkg::FB_FIRST : s_q.fbit + 13'h0001;
         s_d.txb  = 1'b0;
         if (s_q.fbit <= hfo_pkg::FB_SYNC_LAST) begin
            s_d.txb = SYNC_WORD[4'(hfo_pkg::FB_SYNC_LAST - s_q.fbit)];
         end else if (s_q.fbit == hfo_pkg::FB_LOSD) begin
            s_d.txb = s_q.los_s2;
         end else if (s_q.fbit == hfo_pkg::FB_FEBE) begin
            s_d.txb = febe_i;
         end else if (is_z) begin
            s_d.txb = remote ? id_ret[z_idx] : s_q.ztx[z_idx];
         end else if (is_pay) begin
            if (s_q.nb != 3'h0) begin
               s_d.txb = s_q.sh[7];
               s_d.sh  = {s_q.sh[6:0], 1'b0};
               s_d.nb  = s_q.nb - 3'h1;
            end else if (fifo_valid) begin
               s_d.txb = fifo_data[7];
               s_d.sh  = {fifo_data[6:0], 1'b0};
               s_d.nb  = 3'h7;
            end else begin
               // Idle ones when payload runs dry
               s_d.txb = 1'b1;
            end
         end else if (s_q.fbit == hfo_pkg::FB_PS1) begin
            s_d.txb = remote && remote_power_status_a_i;
         end else if (s_q.fbit == hfo_pkg::FB_PS2) begin
            s_d.txb = remote && remote_power_status_b_i;
         end else if (s_q.fbit >= hfo_pkg::FB_REG_FIRST && s_q.fbit <= hfo_pkg::FB_REG_LAST) begin
            s_d.txb = regen_ind_i[2'(hfo_pkg::FB_REG_LAST - s_q.fbit)];
         end else if (s_q.fbit == hfo_pkg::FB_RTR) begin
            s_d.txb = s_q.ctrl[hfo_pkg::CTRL_RTR];
         end
      end else begin
         s_d.fst = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         s_q      <= '0;
         s_q.fbit <= hfo_pkg::FB_FIRST;
         s_q.ctrl <= hfo_pkg::CTRL_RST;
         s_q.ztx  <= hfo_pkg::ZTX_RST;
         s_q.slot <= hfo_pkg::SLOT_RST;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   property p_losd;
      ce_i && advance && s_q.fbit == hfo_pkg::FB_LOSD |=> tx_bit_o == $past(s_q.los_s2);
   endproperty
   a_losd: assert property (p_losd) else $error("losd bit wrong");
   property p_ps;
      ce_i && advance && !remote && s_q.fbit == hfo_pkg::FB_PS1 ##1 ce_i |=> !tx_bit_o;
   endproperty
   a_ps: assert property (p_ps) else $error("power status from central");
   property p_regen;
      ce_i && advance && s_q.fbit == hfo_pkg::FB_REG_FIRST |=> tx_bit_o == $past(regen_ind_i[3]);
   endproperty
   a_regen: assert property (p_regen) else $error("regenerator bit order");
   property p_zid;
      ce_i && advance && !remote && s_q.fbit == hfo_pkg::FB_Z1 |=> tx_bit_o == $past(s_q.ztx[0]);
   endproperty
   a_zid: assert property (p_zid) else $error("Z-bit loop id wrong");
   property p_rev;
      ce_i && s_q.slot[1:0] == 2'h3 && rx_loop_id_valid_i && rx_loop_id_a_i == hfo_pkg::ID_LOOP_B
      && rx_loop_id_b_i == hfo_pkg::ID_LOOP_A |=> path_swap_o;
   endproperty
   a_rev: assert property (p_rev) else $error("reversal not switched");
   property p_rtr;
      ce_i && advance && s_q.fbit == hfo_pkg::FB_RTR |=> tx_bit_o == $past(s_q.ctrl[1]);
   endproperty
   a_rtr: assert property (p_rtr) else $error("ready bit wrong");
   property p_swap;
      loop_swap_o |-> $past(s_q.slot[hfo_pkg::SLOT_SWAP]) && $past(s_q.fail_s2[0], 1);
   endproperty
   a_swap: assert property (p_swap) else $error("swap without cause");
   property p_sync;
      ce_i && advance && s_q.fbit == hfo_pkg::FB_FIRST
      |=> tx_frame_start_o && tx_bit_o == SYNC_WORD[13];
   endproperty
   a_sync: assert property (p_sync) else $error("sync word start wrong");
endmodule

// >>> hdl/hfo_pkg.sv
// Constants shared by the frame overhead block
package hfo_pkg;
   localparam int          FB_W          = 13;
   // Register offsets of the parallel port
   localparam logic [6:0]  REG_CTRL      = 7'h01;
   localparam logic [6:0]  REG_ZTX       = 7'h02;
   localparam logic [6:0]  REG_STAT      = 7'h03;
   localparam logic [6:0]  REG_SLOT      = 7'h06;
   // Reset values
   localparam logic [7:0]  CTRL_RST      = 8'h00;
   localparam logic [2:0]  ZTX_RST       = 3'h0;
   localparam logic [7:0]  SLOT_RST      = 8'h00;
   // Field positions
   localparam int          CTRL_REMOTE   = 0;
   localparam int          CTRL_RTR      = 1;
   localparam int          CTRL_TXEN     = 2;
   localparam int          SLOT_LPR_A    = 0;
   localparam int          SLOT_LPR_B    = 1;
   localparam int          SLOT_SWAP     = 2;
   // Loop identifiers carried in Z-bits 1 to 3
   localparam logic [2:0]  ID_LOOP_A     = 3'h1;
   localparam logic [2:0]  ID_LOOP_B     = 3'h2;
   // Frame bit positions
   localparam logic [12:0] FB_FIRST      = 13'h0001;
   localparam logic [12:0] FB_SYNC_LAST  = 13'h000e;
   localparam logic [12:0] FB_LOSD       = 13'h000f;
   localparam logic [12:0] FB_FEBE       = 13'h0010;
   localparam logic [12:0] FB_Z1         = 13'h0011;
   localparam logic [12:0] FB_BLK_LEN    = 13'h0091;
   localparam logic [12:0] FB_PAY1_LAST  = 13'h06dc;
   localparam logic [12:0] FB_PS1        = 13'h06e3;
   localparam logic [12:0] FB_PS2        = 13'h06e4;
   localparam logic [12:0] FB_PAY2_FIRST = 13'h06e7;
   localparam logic [12:0] FB_PAY2_LAST  = 13'h0db2;
   localparam logic [12:0] FB_REG_FIRST  = 13'h0db9;
   localparam logic [12:0] FB_REG_LAST   = 13'h0dbc;
   localparam logic [12:0] FB_PAY3_FIRST = 13'h0dbd;
   localparam logic [12:0] FB_PAY3_LAST  = 13'h1488;
   localparam logic [12:0] FB_RTR        = 13'h1490;
   localparam logic [12:0] FB_PAY4_FIRST = 13'h1493;
   localparam logic [12:0] FB_PAY4_LAST  = 13'h1b5e;
   localparam logic [12:0] FB_LAST       = 13'h1b62;
endpackage

// >>> verif/hfo_remote_model.sv
// Far-end loop identifier source with optionally crossed wire pairs
`timescale 1ns/100ps
module hfo_remote_model (
   input  wire logic       clk_i,
   input  wire logic       en_i,
   input  wire logic       crossed_i,
   output      logic [2:0] id_a_o,
   output      logic [2:0] id_b_o,
   output      logic       valid_o
);
   initial begin
      valid_o = 1'b0;
      id_a_o  = 3'h5;
      id_b_o  = 3'h2;
   end
   // ids per loop
   // Idle lines keep toggling so a stale id never looks valid
   always @(negedge clk_i) begin
      valid_o <= en_i;
      id_a_o  <= !en_i ? ~id_a_o : crossed_i ? hfo_pkg::ID_LOOP_B : hfo_pkg::ID_LOOP_A;
      id_b_o  <= !en_i ? ~id_b_o : crossed_i ? hfo_pkg::ID_LOOP_A : hfo_pkg::ID_LOOP_B;
   end
endmodule

// >>> verif/hfo_framer_tb.sv
// Self-checking bench for the frame overhead block
`timescale 1ns/100ps
module hfo_framer_tb;
   localparam logic [13:0] SYNC = 14'h2b67;
   logic       clk_i = 1'b0;
   logic       rst_b_i = 1'b0;
   logic       ce = 1'b1;
   logic [6:0] addr_i = 7'h00;
   logic       wr_i = 1'b0;
   logic       rd_i = 1'b0;
   logic [7:0] wr_data_i = 8'h00;
   logic [7:0] rd_data_o;
   logic       loss = 1'b0;
   logic       febe = 1'b0;
   logic [1:0] pwr = 2'h0;
   logic [3:0] regen = 4'h0;
   logic [2:0] id_a;
   logic [2:0] id_b;
   logic       id_ok;
   logic       crossed = 1'b0;
   logic       id_en = 1'b0;
   logic [1:0] fail = 2'h0;
   logic       pay_v = 1'b0;
   logic       pay_rdy;
   logic [7:0] pay_d = 8'h00;
   logic       tx_bit;
   logic       fstart;
   logic       pswap;
   logic       lswap;
   logic       fr [1:7010];
   int         mismatches = 0;
   int         cmp_count = 0;
   int         n;

   initial forever #2.5 clk_i = ~clk_i;

   hfo_framer #(.SYNC_WORD(SYNC)) hfo_framer_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce),
      .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
      .far_end_loss_i(loss), .febe_i(febe), .remote_power_status_a_i(pwr[1]),
      .remote_power_status_b_i(pwr[0]), .regen_ind_i(regen), .rx_loop_id_a_i(id_a),
      .rx_loop_id_b_i(id_b), .rx_loop_id_valid_i(id_ok), .loop_fail_i(fail),
      .pay_valid_i(pay_v), .pay_ready_o(pay_rdy), .pay_data_i(pay_d), .tx_bit_o(tx_bit),
      .tx_frame_start_o(fstart), .path_swap_o(pswap), .loop_swap_o(lswap));
   hfo_remote_model hfo_remote_model_i (.clk_i(clk_i), .en_i(id_en), .crossed_i(crossed),
      .id_a_o(id_a), .id_b_o(id_b), .valid_o(id_ok));

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr_i = a;
      wr_data_i = d;
      wr_i = 1'b1;
      @(negedge clk_i);
      wr_i = 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] exp, input string name);
      @(negedge clk_i);
      addr_i = a;
      rd_i = 1'b1;
      @(negedge clk_i);
      rd_i = 1'b0;
      check(name, {8'h00, exp}, {8'h00, rd_data_o});
   endtask
   // Records one whole frame starting at frame bit 1
   task automatic grab();
      for (int i = 0; i < 7100 && fstart !== 1'b1; i++)
         @(negedge clk_i);
      for (int i = 1; i <= 7010; i++) begin
         fr[i] = tx_bit;
         @(negedge clk_i);
      end
   endtask
   function automatic logic [15:0] bits(input int p, input int w);
      bits = 16'h0000;
      for (int i = 0; i < w; i++)
         bits = {bits[14:0], fr[p+i]};
   endfunction
   function automatic logic [15:0] zb();
      zb = {13'h0000, fr[307], fr[162], fr[17]};
   endfunction
   task automatic settle(input logic exp_p, input logic exp_l);
      repeat (5) @(negedge clk_i);
      check("path swap", {15'h0, exp_p}, {15'h0, pswap});
      check("loop swap", {15'h0, exp_l}, {15'h0, lswap});
   endtask

   initial begin
      #400000;
      mismatches++;
      summarize();
   end

   initial begin
      repeat (6) @(negedge clk_i);
      rst_b_i = 1'b1;
      rd(hfo_pkg::REG_CTRL, hfo_pkg::CTRL_RST, "ctrl reset");
      rd(hfo_pkg::REG_SLOT, hfo_pkg::SLOT_RST, "slot reset");
      wr(7'h05, 8'hff);
      rd(7'h05, 8'h00, "unmapped");
      wr(hfo_pkg::REG_SLOT, 8'h07);
      rd(hfo_pkg::REG_SLOT, 8'h07, "slot rw");
      wr(hfo_pkg::REG_SLOT, 8'h00);
      $display("test registers done");

      // Central unit, buffer filled while transmit is off
      wr(hfo_pkg::REG_ZTX, {5'h00, hfo_pkg::ID_LOOP_B});
      rd(hfo_pkg::REG_ZTX, {5'h00, hfo_pkg::ID_LOOP_B}, "ztx rw");
      loss = 1'b1;
      febe = 1'b1;
      // Unequal bits so a swapped pair shows
      pwr = 2'h2;
      regen = 4'ha;
      n = 0;
      pay_v = 1'b1;
      for (int i = 0; i < 12; i++) begin
         if (pay_rdy === 1'b1)
            n++;
         pay_d = 8'(i);
         @(negedge clk_i);
      end
      pay_v = 1'b0;
      check("fifo fill", 16'd8, 16'(n));
      wr(hfo_pkg::REG_CTRL, 8'h06);
      grab();
      check("sync", {2'b00, SYNC}, bits(1, 14));
      check("loss", 16'h1, bits(15, 1));
      check("febe", 16'h1, bits(16, 1));
      check("payload first", 16'h0001, bits(18, 16));
      check("payload last", 16'h07ff, bits(74, 16));
      check("power central", 16'h0, bits(1763, 2));
      check("regen", 16'ha, bits(3513, 4));
      check("ready central", 16'h1, bits(5264, 1));
      check("z central", {13'h0, hfo_pkg::ID_LOOP_B}, zb());
      check("fifo drained", 16'h1, {15'h0, pay_rdy});
      $display("test central frame done");

      // Remote unit, straight wiring, not yet ready
      id_en = 1'b1;
      wr(hfo_pkg::REG_CTRL, 8'h05);
      grab();
      check("power remote", 16'h2, bits(1763, 2));
      check("ready remote", 16'h0, bits(5264, 1));
      check("z remote", {13'h0, hfo_pkg::ID_LOOP_A}, zb());
      $display("test remote frame done");

      // Crossed pairs: one enable alone must not switch
      crossed = 1'b1;
      wr(hfo_pkg::REG_SLOT, 8'h01);
      settle(1'b0, 1'b0);
      wr(hfo_pkg::REG_SLOT, 8'h03);
      settle(1'b1, 1'b0);
      rd(hfo_pkg::REG_STAT, 8'h15, "status");
      grab();
      check("z corrected", {13'h0, hfo_pkg::ID_LOOP_A}, zb());
      crossed = 1'b0;
      settle(1'b0, 1'b0);
      $display("test reversal done");

      // Loop swap only while primary alone has failed
      wr(hfo_pkg::REG_SLOT, 8'h04);
      fail = 2'h1;
      settle(1'b0, 1'b1);
      fail = 2'h3;
      settle(1'b0, 1'b0);
      wr(hfo_pkg::REG_SLOT, 8'h00);
      fail = 2'h1;
      settle(1'b0, 1'b0);
      $display("test loop swap done");

      // Enable low freezes registers; mid-run reset clears them
      ce = 1'b0;
      wr(hfo_pkg::REG_CTRL, 8'h00);
      ce = 1'b1;
      rd(hfo_pkg::REG_CTRL, 8'h05, "ctrl frozen");
      wr(hfo_pkg::REG_SLOT, 8'h04);
      rst_b_i = 1'b0;
      repeat (2) @(negedge clk_i);
      rst_b_i = 1'b1;
      rd(hfo_pkg::REG_SLOT, hfo_pkg::SLOT_RST, "slot after reset");
      rd(hfo_pkg::REG_CTRL, hfo_pkg::CTRL_RST, "ctrl after reset");
      settle(1'b0, 1'b0);
      $display("test freeze and reset done");
      summarize();
   end
endmodule
